// ==== sar_ctrl_pkg.sv ====
// Constants and carriers for the converter start and accumulate block.
// Assumes a single 20 MHz system clock with synchronous active-high reset.
package sar_ctrl_pkg;
	localparam int          CLOCK_HZ        = 20_000_000;
	localparam int          CODE_W          = 10;
	localparam int          ACC_W           = 16;
	localparam int          BIT_CYCLES      = 11;
	localparam logic [2:0]  SRC_SOFTWARE    = 3'h0;
	localparam logic [2:0]  SRC_TIMER0      = 3'h1;
	localparam logic [2:0]  SRC_TIMER2      = 3'h2;
	localparam logic [2:0]  SRC_TIMER3      = 3'h3;
	localparam logic [2:0]  SRC_EXTERNAL    = 3'h4;
	localparam logic [2:0]  SRC_TIMER1      = 3'h5;
	localparam logic [2:0]  JUST_LEFT       = 3'h4;
	localparam logic [2:0]  RPT_1           = 3'h0;
	localparam logic [6:0]  RPT_COUNT_1     = 7'h01;
	localparam logic [6:0]  RPT_COUNT_4     = 7'h04;
	localparam logic [6:0]  RPT_COUNT_8     = 7'h08;
	localparam logic [6:0]  RPT_COUNT_16    = 7'h10;
	localparam logic [6:0]  RPT_COUNT_32    = 7'h20;
	localparam logic [6:0]  RPT_COUNT_64    = 7'h40;
	localparam logic [5:0]  LEFT_SHIFT      = 6'h06;
	localparam logic [7:0]  BYTE_ZERO       = 8'h00;
	localparam logic [15:0] ACC_ZERO        = 16'h0000;

	typedef struct packed {
		logic [2:0] start_source_select;
		logic [2:0] justify_shift_select;
		logic [2:0] repeat_count_field;
		logic [4:0] clock_divider_field;
		logic       burst_enable_bit;
		logic       sync_enable;
		logic       conv_clock_invert_bit;
	} conv_cfg_t;

	typedef struct packed {
		logic timer0_ovf;
		logic timer1_ovf;
		logic timer2_low_ovf;
		logic timer2_high_ovf;
		logic timer2_split;
		logic timer3_low_ovf;
		logic timer3_high_ovf;
		logic timer3_split;
	} timer_ev_t;
endpackage : sar_ctrl_pkg

// ==== sar_start_accum.sv ====
// Start source selection, conversion clock, busy/done flags and accumulation.
// Assumes the analog core takes one conversion clock per bit and returns its code
// on core_code with core_done; timer events are same-clock pulses.
// Function
// [R1] Result bytes written when conversion finishes
// [R2] Single sample: right or left 10-bit code
// [R3] Unused result bits read as zero
// [R4] Accumulate series, update after last conversion
// [R5] Repeat counts 4, 8, 16, 32, 64
// [R6] Software keeps right justify when accumulating
// [R7] 16-bit accumulator, shift right 1-3
// [R8] Conversion clock from sysclk or low-power osc
// [R9] Software keeps throughput under 300 ksps
// [R10] Start from selected source
// [R11] Busy high through whole conversion
// [R12] Busy falling edge sets done flag
// [R13] Software polls done flag, not busy
// [R14] Timer 2/3 low or high overflow
// [R15] Software skips shared pin for external start
// [R16] Sync delays start until converter pulse
// [R17] Sync uses converter clock, divide one
// [R18] Optional inversion of converter clock
// [R19] Software clears sync in two-cell mode
// [R20] Source 100 is external start input
// [R21] Done only after full repeat count
// [R22] Accumulator cleared at series start
`timescale 1ns/1ps
`default_nettype none
module sar_start_accum
	import sar_ctrl_pkg::*;
(
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire conv_cfg_t        cfg,
	input  wire logic             busy_write_one,
	input  wire logic             done_clear,
	input  wire timer_ev_t        timer_ev,
	input  wire logic             external_start_input,
	input  wire logic             lp_osc_tick,
	input  wire logic             dcdc_clock,
	input  wire logic [9:0]       core_code,
	input  wire logic             core_done,
	output var  logic             conversion_clock,
	output var  logic             core_start,
	output var  logic             conversion_busy_bit,
	output var  logic             conversion_done_flag,
	output var  logic             window_compare_strobe,
	output var  logic [7:0]       result_high_byte,
	output var  logic [7:0]       result_low_byte
);
	typedef enum logic [1:0] {IDLE, WAIT_SYNC, CONVERT} state_t;

	state_t      state_reg, state_next;
	logic [1:0]  ext_sync_reg, dcdc_sync_reg;
	logic        ext_prev_reg, dcdc_prev_reg;
	logic [4:0]  div_cnt_reg;
	logic [6:0]  sample_cnt_reg;
	logic [15:0] acc_reg;
	logic        busy_prev_reg;

	// [R20] External start edge
	wire ext_rise  = ext_sync_reg[1] & ~ext_prev_reg;
	// [R18] Converter clock invert
	wire dcdc_lvl  = dcdc_sync_reg[1] ^ cfg.conv_clock_invert_bit;
	wire sync_tick = dcdc_lvl & ~dcdc_prev_reg;
	// [R14] Timer overflow width
	wire t2_ev = timer_ev.timer2_split ? timer_ev.timer2_low_ovf : timer_ev.timer2_high_ovf;
	wire t3_ev = timer_ev.timer3_split ? timer_ev.timer3_low_ovf : timer_ev.timer3_high_ovf;
	// [R10] Start source mux
	wire start_req =
		(cfg.start_source_select == SRC_SOFTWARE) ? busy_write_one :
		(cfg.start_source_select == SRC_TIMER0)   ? timer_ev.timer0_ovf :
		(cfg.start_source_select == SRC_TIMER2)   ? t2_ev :
		(cfg.start_source_select == SRC_TIMER3)   ? t3_ev :
		(cfg.start_source_select == SRC_EXTERNAL) ? ext_rise :
		(cfg.start_source_select == SRC_TIMER1)   ? timer_ev.timer1_ovf : 1'b0;

	// [R8] Clock source and divider
	wire src_tick = cfg.burst_enable_bit ? lp_osc_tick : 1'b1;
	wire div_wrap = src_tick && (div_cnt_reg >= cfg.clock_divider_field);

	// [R5] Repeat count decode
	wire [6:0] rpt_target =
		(cfg.repeat_count_field == 3'h1) ? RPT_COUNT_4 :
		(cfg.repeat_count_field == 3'h2) ? RPT_COUNT_8 :
		(cfg.repeat_count_field == 3'h3) ? RPT_COUNT_16 :
		(cfg.repeat_count_field == 3'h4) ? RPT_COUNT_32 :
		(cfg.repeat_count_field == 3'h5) ? RPT_COUNT_64 : RPT_COUNT_1;

	wire        sample_done = (state_reg == CONVERT) && core_done;
	wire        first_smp   = (sample_cnt_reg == 7'h00);
	// [R22] Fresh sum at series start
	wire [15:0] acc_base    = first_smp ? ACC_ZERO : acc_reg;
	// [R4] Unsigned accumulation
	wire [15:0] acc_sum     = acc_base + {6'h00, core_code};
	wire        last_smp    = sample_done && ((sample_cnt_reg + 7'h01) == rpt_target);

	// [R7] Right shift of the sum
	wire [1:0]  shamt       = cfg.justify_shift_select[1:0];
	wire [15:0] shifted     = acc_sum >> shamt;
	// [R2] Left justify only meaningful for single samples
	wire        left_j      = (cfg.justify_shift_select == JUST_LEFT) &&
		(cfg.repeat_count_field == RPT_1);
	// [R3] Zero fill in unused bits
	wire [15:0] formatted   = left_j ? (acc_sum << LEFT_SHIFT) : shifted;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			IDLE:      if (start_req) state_next = cfg.sync_enable ? WAIT_SYNC : CONVERT;
			// [R16] Hold off until sync pulse
			WAIT_SYNC: if (sync_tick) state_next = CONVERT;
			// [R11] Busy through conversion
			CONVERT:   if (core_done) state_next = IDLE;
			default:   state_next = IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ext_sync_reg  <= 2'h0;
			dcdc_sync_reg <= 2'h0;
			ext_prev_reg  <= 1'b0;
			dcdc_prev_reg <= 1'b0;
		end else begin
			ext_sync_reg  <= {ext_sync_reg[0], external_start_input};
			dcdc_sync_reg <= {dcdc_sync_reg[0], dcdc_clock};
			ext_prev_reg  <= ext_sync_reg[1];
			dcdc_prev_reg <= dcdc_lvl;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			div_cnt_reg      <= 5'h00;
			conversion_clock <= 1'b0;
		end else if (cfg.sync_enable) begin
			// [R17] Converter clock passed through, divide by one
			div_cnt_reg      <= 5'h00;
			conversion_clock <= dcdc_lvl;
		end else if (src_tick) begin
			div_cnt_reg      <= div_wrap ? 5'h00 : div_cnt_reg + 5'h01;
			conversion_clock <= div_wrap ? ~conversion_clock : conversion_clock;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg           <= IDLE;
			core_start          <= 1'b0;
			conversion_busy_bit <= 1'b0;
			busy_prev_reg       <= 1'b0;
		end else begin
			state_reg           <= state_next;
			core_start          <= (state_reg != CONVERT) && (state_next == CONVERT);
			conversion_busy_bit <= (state_next != IDLE);
			busy_prev_reg       <= conversion_busy_bit;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sample_cnt_reg <= 7'h00;
			acc_reg        <= ACC_ZERO;
		end else if (sample_done) begin
			sample_cnt_reg <= last_smp ? 7'h00 : sample_cnt_reg + 7'h01;
			acc_reg        <= acc_sum;
		end
	end

	// [R1] Result bytes on completion
	always_ff @(posedge clock) begin
		if (reset) begin
			result_high_byte <= BYTE_ZERO;
			result_low_byte  <= BYTE_ZERO;
		end else if (last_smp) begin
			result_high_byte <= formatted[15:8];
			result_low_byte  <= formatted[7:0];
		end
	end

	// [R12] Done flag; set wins over clear
	// [R21] Only after full series
	wire busy_fall  = busy_prev_reg & ~conversion_busy_bit;
	logic series_end_reg;
	always_ff @(posedge clock) begin
		if (reset) begin
			series_end_reg        <= 1'b0;
			conversion_done_flag  <= 1'b0;
			window_compare_strobe <= 1'b0;
		end else begin
			series_end_reg        <= last_smp ? 1'b1 : (busy_fall ? 1'b0 : series_end_reg);
			conversion_done_flag  <= (busy_fall && series_end_reg) ? 1'b1 :
				(done_clear ? 1'b0 : conversion_done_flag);
			window_compare_strobe <= busy_fall && series_end_reg;
		end
	end

	// Assertions
	busy_in_conv_a: assert property (@(posedge clock) disable iff (reset) // [R11]
		(state_reg == CONVERT) |-> conversion_busy_bit)
		else $error("busy low during conversion");
	done_on_fall_a: assert property (@(posedge clock) disable iff (reset) // [R12]
		$fell(conversion_busy_bit) && series_end_reg |=> conversion_done_flag)
		else $error("done not set on busy fall");
	done_needs_series_a: assert property (@(posedge clock) disable iff (reset) // [R21]
		$rose(conversion_done_flag) |-> $past(series_end_reg))
		else $error("done set before series end");
	result_hold_a: assert property (@(posedge clock) disable iff (reset) // [R4]
		!$past(last_smp) |-> $stable(result_high_byte) && $stable(result_low_byte))
		else $error("result changed mid series");
	sw_start_a: assert property (@(posedge clock) disable iff (reset) // [R10]
		state_reg == IDLE && cfg.start_source_select == SRC_SOFTWARE && busy_write_one
		&& !cfg.sync_enable |=> state_reg == CONVERT ##0 conversion_busy_bit)
		else $error("software start missed");
	sync_hold_a: assert property (@(posedge clock) disable iff (reset) // [R16]
		state_reg == WAIT_SYNC && !sync_tick |=> state_reg == WAIT_SYNC)
		else $error("start not held for sync");
	right_zero_a: assert property (@(posedge clock) disable iff (reset) // [R3]
		last_smp && cfg.repeat_count_field == RPT_1 && cfg.justify_shift_select == RPT_1
		|=> result_high_byte[7:2] == 6'h00)
		else $error("unused high bits not zero");
	left_zero_a: assert property (@(posedge clock) disable iff (reset) // [R2]
		last_smp && left_j |=> result_low_byte[5:0] == 6'h00)
		else $error("left justify low bits not zero");
	clear_first_a: assert property (@(posedge clock) disable iff (reset) // [R22]
		sample_done && first_smp |=> acc_reg == {6'h00, $past(core_code)})
		else $error("accumulator not cleared");
	sync_clock_a: assert property (@(posedge clock) disable iff (reset) // [R17]
		cfg.sync_enable |=> conversion_clock == $past(dcdc_lvl))
		else $error("conversion clock not following converter clock");

	cov_single_c: cover property (@(posedge clock) last_smp && rpt_target == RPT_COUNT_1);
	cov_accum64_c: cover property (@(posedge clock) last_smp && rpt_target == RPT_COUNT_64);
	cov_sync_c: cover property (@(posedge clock) state_reg == WAIT_SYNC ##1 state_reg == CONVERT);
	cov_ext_c: cover property (@(posedge clock) ext_rise && state_reg == IDLE);
endmodule : sar_start_accum
`default_nettype wire

// ==== sar_core_model.sv ====
// Behavioural model of the analog converter core on the far side.
// Assumes core_start is a one-cycle pulse from the control block.
`timescale 1ns/1ps
`default_nettype none
module sar_core_model
	import sar_ctrl_pkg::*;
#(
	parameter int LAT = BIT_CYCLES
)(
	input  wire logic       clock,
	input  wire logic       core_start,
	input  wire logic       slow,
	input  wire logic [9:0] code_in,
	output var  logic [9:0] core_code = 10'h000,
	output var  logic       core_done = 1'b0
);
	int cnt = 0;
	// One conversion per start
	// Idle code shows the inverse, so a late sample cannot pass by chance
	always_ff @(posedge clock) begin
		core_done <= 1'b0;
		if (core_done)
			core_code <= ~core_code;
		if (core_start)
			cnt <= slow ? 4 * LAT : LAT;
		else if (cnt == 1) begin
			core_done <= 1'b1;
			core_code <= code_in;
			cnt       <= 0;
		end else if (cnt > 1)
			cnt <= cnt - 1;
	end
endmodule : sar_core_model
`default_nettype wire

// ==== sar_start_accum_bench.sv ====
// Self-checking bench for the start and accumulate block.
// Assumes the core model answers each core_start with one core_done.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) tests_run++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end
module sar_start_accum_bench;
	import sar_ctrl_pkg::*;
	logic       clock = 1'b0, reset = 1'b1, busy_write_one = 1'b0, done_clear = 1'b0;
	logic       ext = 1'b0, slow = 1'b0, lp_tick = 1'b0, dcdc = 1'b0, strobe;
	conv_cfg_t  cfg = '0;
	timer_ev_t  timer_ev = '0;
	logic [9:0] code_in = 10'h000, core_code;
	logic       core_done, conversion_clock, core_start, busy, done;
	logic [7:0] hi, lo;
	int         failures = 0, tests_run = 0;
	sar_start_accum sar_start_accum_inst (.clock(clock), .reset(reset), .cfg(cfg),
		.busy_write_one(busy_write_one), .done_clear(done_clear), .timer_ev(timer_ev),
		.external_start_input(ext), .lp_osc_tick(lp_tick), .dcdc_clock(dcdc),
		.core_code(core_code), .core_done(core_done), .conversion_clock(conversion_clock),
		.core_start(core_start), .conversion_busy_bit(busy), .conversion_done_flag(done),
		.window_compare_strobe(strobe), .result_high_byte(hi), .result_low_byte(lo));
	sar_core_model sar_core_model_inst (.clock(clock), .core_start(core_start), .slow(slow),
		.code_in(code_in), .core_code(core_code), .core_done(core_done));
	initial forever #25 clock = ~clock;
	// Converter clock at 2.5 MHz, free running, edges away from the sampling edge
	initial forever #200 dcdc = ~dcdc;
	// Low-power oscillator tick on every other system clock
	always @(negedge clock) lp_tick <= ~lp_tick;
	localparam int MIN_START_CYCLES = CLOCK_HZ / 300_000 + 1;
	localparam int DCDC_HALF        = 4;
	task conclude;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	task wait_for(input logic lvl, input int lim);
		int i;
		for (i = 0; i < lim && busy !== lvl; i++) @(negedge clock);
		if (busy !== lvl) begin
			failures++;
			conclude();
		end
	endtask : wait_for
	task series(input logic [2:0] src, rpt, just, input logic [9:0] code, input int n);
		logic [15:0] exp;
		int          k;
		exp = just[2] ? {code, 6'h00} : 16'(n * code) >> just[1:0];
		cfg.start_source_select = src;
		cfg.repeat_count_field = rpt;
		cfg.justify_shift_select = just;
		code_in = code;
		for (k = 0; k < n; k++) begin
			@(negedge clock);
			case (src)
				SRC_SOFTWARE: busy_write_one = 1'b1;
				SRC_TIMER0: timer_ev.timer0_ovf = 1'b1;
				SRC_TIMER1: timer_ev.timer1_ovf = 1'b1;
				SRC_TIMER2: timer_ev.timer2_low_ovf = 1'b1;
				SRC_TIMER3: timer_ev.timer3_high_ovf = 1'b1;
				default: ext = 1'b1;
			endcase
			@(negedge clock);
			busy_write_one = 1'b0;
			timer_ev.timer0_ovf = 1'b0;
			timer_ev.timer1_ovf = 1'b0;
			timer_ev.timer2_low_ovf = 1'b0;
			timer_ev.timer3_high_ovf = 1'b0;
			wait_for(1'b1, 8);
			wait_for(1'b0, 300);
			// Done and strobe only after last sample
			@(negedge clock);
			`CHK("window strobe", k == n - 1, strobe)
			`CHK("done mid series", k == n - 1, done)
			@(negedge clock);
			`CHK("strobe pulse", 1'b0, strobe)
			ext = 1'b0;
			// Starts no faster than 300 ksps
			repeat (MIN_START_CYCLES) @(negedge clock);
		end
		// Poll the done flag, not busy
		`CHK("done flag", 1'b1, done)
		`CHK("result", exp, {hi, lo})
		done_clear = 1'b1;
		@(negedge clock);
		done_clear = 1'b0;
		@(negedge clock);
		`CHK("done cleared", 1'b0, done)
	endtask : series
	// Half period of the conversion clock
	task clock_div(input logic burst, input logic [4:0] div, input int half);
		logic last;
		int   c, t, mark;
		cfg.burst_enable_bit = burst;
		cfg.clock_divider_field = div;
		last = conversion_clock;
		t = 0;
		mark = 0;
		for (c = 0; c < 400 && t < 3; c++) begin
			@(negedge clock);
			if (conversion_clock !== last) begin
				t++;
				last = conversion_clock;
				if (t == 2)
					mark = c;
				if (t == 3) begin
					`CHK("clock half period", half, c - mark)
				end
			end
		end
		if (t < 3) begin
			failures++;
			conclude();
		end
	endtask : clock_div
	// One-cell runs, starts held for converter edge
	task sync_run(input logic inv);
		int c;
		cfg.sync_enable = 1'b1;
		cfg.conv_clock_invert_bit = inv;
		// Divider left at zero under sync
		clock_div(1'b0, 5'h00, DCDC_HALF);
		for (c = 0; c < 20 && conversion_clock !== 1'b0; c++) @(negedge clock);
		for (c = 0; c < 20 && conversion_clock !== 1'b1; c++) @(negedge clock);
		`CHK("sync clock high", 1'b1, conversion_clock)
		`CHK("sync clock phase", ~inv, dcdc)
		series(SRC_SOFTWARE, RPT_1, 3'h0, 10'h1C3, 1);
		// Sync cleared again for two-cell use
		cfg.sync_enable = 1'b0;
		cfg.conv_clock_invert_bit = 1'b0;
	endtask : sync_run
	initial begin
		repeat (12) @(negedge clock);
		reset = 1'b0;
		`CHK("busy after reset", 1'b0, busy)
		series(SRC_SOFTWARE, RPT_1, 3'h0, 10'h3FF, 1);
		series(SRC_SOFTWARE, RPT_1, JUST_LEFT, 10'h3FF, 1);
		series(SRC_SOFTWARE, RPT_1, JUST_LEFT, 10'h200, 1);
		series(SRC_SOFTWARE, 3'h1, 3'h0, 10'h3FF, 4);
		series(SRC_SOFTWARE, 3'h5, 3'h3, 10'h3FF, 64);
		series(SRC_SOFTWARE, 3'h3, 3'h2, 10'h200, 16);
		series(SRC_SOFTWARE, 3'h2, 3'h0, 10'h001, 8);
		series(SRC_SOFTWARE, 3'h4, 3'h1, 10'h155, 32);
		slow = 1'b1;
		timer_ev.timer2_split = 1'b1;
		series(SRC_TIMER0, RPT_1, 3'h0, 10'h155, 1);
		series(SRC_TIMER2, RPT_1, 3'h0, 10'h2AA, 1);
		series(SRC_TIMER3, RPT_1, 3'h0, 10'h0F0, 1);
		series(SRC_TIMER1, RPT_1, 3'h0, 10'h0AB, 1);
		series(SRC_EXTERNAL, RPT_1, 3'h0, 10'h30F, 1);
		slow = 1'b0;
		clock_div(1'b0, 5'h03, 4);
		clock_div(1'b1, 5'h02, 6);
		clock_div(1'b0, 5'h00, 1);
		sync_run(1'b0);
		sync_run(1'b1);
		conclude();
	end
endmodule : sar_start_accum_bench
`default_nettype wire
